/* tec_consts.svh */
// Register offsets, field masks and reset values of the three-channel timer
`ifndef TEC_CONSTS_SVH
`define TEC_CONSTS_SVH
`define TEC_OFF_MODE2   12'hf90
`define TEC_OFF_CTRL2   12'hf94
`define TEC_OFF_MODE0   12'hfa0
`define TEC_OFF_OE0     12'hfa4
`define TEC_OFF_MODE1   12'hfa8
`define TEC_OFF_OE1     12'hfac
`define TEC_OFF_MOD0    12'hfb0
`define TEC_OFF_MOD1    12'hfb4
`define TEC_OFF_MOD2    12'hfb8
`define TEC_OFF_CNT0    12'hfc0
`define TEC_OFF_CNT1    12'hfc4
`define TEC_OFF_CNT2    12'hfc8
`define TEC_OFF_IRQ     12'hfcc
`define TEC_MASK_MODE0  8'h7c
`define TEC_MASK_MODE12 8'h7f
`define TEC_MASK_CTRL2  8'h8f
`define TEC_RST_BYTE    8'h00
`define TEC_RST_MOD     8'hff
`define TEC_PRE_W       12
`define TEC_PRE_RST     12'h000
`define TEC_CNT_MAX     8'hff
`endif

/* tec_pkg.sv */
// Types shared by the timer block: bus carriers, register layouts, codes
package tec_pkg;
    typedef enum logic [2:0] {
        SRC_RISE = 3'b000, SRC_FALL = 3'b001, SRC_2 = 3'b010, SRC_3 = 3'b011,
        SRC_4    = 3'b100, SRC_5    = 3'b101, SRC_6 = 3'b110, SRC_7 = 3'b111
    } tec_src_e;
    typedef enum logic [1:0] {
        MODE_8BIT = 2'b00, MODE_PWM = 2'b01, MODE_16BIT = 2'b10, MODE_CARRIER = 2'b11
    } tec_mode_e;
    typedef struct packed {
        logic      rsv;
        tec_src_e  src;
        logic      start_cmd;
        logic      run;
        tec_mode_e mode;
    } tec_mode_s;
    typedef struct packed {
        logic       gate_ctrl_enable;
        logic [2:0] rsv;
        logic       out_enable;
        logic       carrier_suppress;
        logic       level_data_next;
        logic       level_data;
    } tec_ctrl2_s;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } tec_apb_req_s;
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } tec_apb_rsp_s;
endpackage : tec_pkg

/* tec_top.sv */
// Three-channel 8-bit timer/event counter with APB register access
`timescale 1ns/100ps
`include "tec_consts.svh"
module tec_top (
    input  wire logic                i_core_clk,
    input  wire logic                i_nrst,
    input  wire tec_pkg::tec_apb_req_s i_apb,
    output tec_pkg::tec_apb_rsp_s    o_apb,
    input  wire logic [2:0]          i_event_in,
    output logic                     o_ch0_out_pin,
    output logic                     o_ch1_out_pin,
    output logic                     o_ch2_out_pin,
    output logic [2:0]               o_irq_flag
);
    import tec_pkg::*;

    // ******************************************************
    // State
    // ******************************************************
    tec_mode_s    mode_ff [3];
    tec_ctrl2_s   ctrl2_ff;
    logic [1:0]   oe_ff;
    logic [7:0]   mod_ff [3];
    logic [7:0]   cnt_ff [3];
    logic [2:0]   irq_ff;
    logic [2:0]   tout_ff;
    logic [`TEC_PRE_W-1:0] pre_ff;
    logic [2:0]   sync1_ff;
    logic [2:0]   sync2_ff;
    logic [2:0]   sync3_ff;
    tec_apb_rsp_s rsp_ff;
    logic [12:1]  tk;
    logic [2:0]   rise;
    logic [2:0]   fall;
    logic [2:0]   cp;
    logic [2:0]   en;
    logic [2:0]   match;
    logic         wr;
    logic         carrier_mode;
    logic         pwm_mode;
    logic         remote_out;
    tec_apb_rsp_s nxt_rsp;

    // ******************************************************
    // Prescaler and event pin synchronisers
    // ******************************************************
    // Free-running divider; each fx/2^k rate is a one-cycle enable
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            pre_ff <= `TEC_PRE_RST;
        end else begin
            pre_ff <= pre_ff + 1'b1;
        end
    end

    for (genvar k = 1; k <= 12; k++) begin : g_tick
        assign tk[k] = &pre_ff[k-1:0];
    end

    // Three stages: edge detect only looks at stages two and three
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
            sync3_ff <= 3'h0;
        end else begin
            sync1_ff <= i_event_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    assign rise = sync2_ff & ~sync3_ff;
    assign fall = ~sync2_ff & sync3_ff;

    // ******************************************************
    // Count pulse selection and run gating
    // ******************************************************
    assign carrier_mode = (mode_ff[1].mode == MODE_8BIT)
                          && (mode_ff[2].mode == MODE_CARRIER);
    assign pwm_mode     = (mode_ff[2].mode == MODE_PWM);

    // Prohibited source codes on channel 0 give no pulse at all
    always_comb begin
        unique case (mode_ff[0].src)
            SRC_RISE: cp[0] = rise[0];
            SRC_FALL: cp[0] = fall[0];
            SRC_4:    cp[0] = tk[10];
            SRC_5:    cp[0] = tk[8];
            SRC_6:    cp[0] = tk[6];
            SRC_7:    cp[0] = tk[4];
            default:  cp[0] = 1'b0;
        endcase
        unique case (mode_ff[1].src)
            SRC_RISE: cp[1] = rise[1];
            SRC_FALL: cp[1] = fall[1];
            SRC_2:    cp[1] = match[2];
            SRC_3:    cp[1] = tk[5];
            SRC_4:    cp[1] = tk[12];
            SRC_5:    cp[1] = tk[10];
            SRC_6:    cp[1] = tk[8];
            SRC_7:    cp[1] = tk[6];
        endcase
        // Cascade: upper byte advances on every lower byte wrap
        if (mode_ff[1].mode == MODE_16BIT) begin
            cp[1] = match[2];
        end
        unique case (mode_ff[2].src)
            SRC_RISE: cp[2] = rise[2];
            SRC_FALL: cp[2] = fall[2];
            SRC_2:    cp[2] = tk[1];
            SRC_3:    cp[2] = 1'b1;
            SRC_4:    cp[2] = tk[10];
            SRC_5:    cp[2] = tk[8];
            SRC_6:    cp[2] = tk[6];
            SRC_7:    cp[2] = tk[4];
        endcase
    end

    // Channel 0 toggle output serves as the sampling clock for gating
    assign en[0] = mode_ff[0].run;
    assign en[1] = mode_ff[1].run;
    assign en[2] = mode_ff[2].run
                   && (!ctrl2_ff.gate_ctrl_enable || tout_ff[0]);

    // Match is the interval event; blocked in the start-clear cycle
    for (genvar n = 0; n < 3; n++) begin : g_match
        if (n == 2) begin : g_pwm
            assign match[n] = cp[n] && en[n] && !mode_ff[n].start_cmd
                && (pwm_mode ? cnt_ff[n] == `TEC_CNT_MAX : cnt_ff[n] == mod_ff[n]);
        end else begin : g_std
            assign match[n] = cp[n] && en[n] && !mode_ff[n].start_cmd
                && (cnt_ff[n] == mod_ff[n]);
        end
    end

    // ******************************************************
    // Counters, interrupt flags and toggle outputs
    // ******************************************************
    // Counter clears on start, wraps on match, else holds or advances
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            for (int n = 0; n < 3; n++) begin
                cnt_ff[n] <= `TEC_RST_BYTE;
            end
        end else begin
            for (int n = 0; n < 3; n++) begin
                if (mode_ff[n].start_cmd) begin
                    cnt_ff[n] <= `TEC_RST_BYTE;
                end else if (match[n]) begin
                    cnt_ff[n] <= `TEC_RST_BYTE;
                end else if (cp[n] && en[n]) begin
                    cnt_ff[n] <= cnt_ff[n] + 8'h01;
                end
            end
        end
    end

    // Set beats any clear arriving in the same cycle
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            irq_ff <= 3'h0;
        end else begin
            for (int n = 0; n < 3; n++) begin
                if (match[n]) begin
                    irq_ff[n] <= 1'b1;
                end else if (mode_ff[n].start_cmd) begin
                    irq_ff[n] <= 1'b0;
                end else if (wr && i_apb.paddr == `TEC_OFF_IRQ && i_apb.pwdata[n]) begin
                    irq_ff[n] <= 1'b0;
                end
            end
        end
    end

    // PWM: high while the count is below the modulo value
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            tout_ff <= 3'h0;
        end else begin
            for (int n = 0; n < 2; n++) begin
                if (mode_ff[n].start_cmd) begin
                    tout_ff[n] <= 1'b0;
                end else if (match[n]) begin
                    tout_ff[n] <= ~tout_ff[n];
                end
            end
            if (pwm_mode) begin
                tout_ff[2] <= cnt_ff[2] < mod_ff[2];
            end else if (match[2]) begin
                tout_ff[2] <= ~tout_ff[2];
            end
        end
    end

    // ******************************************************
    // Pins
    // ******************************************************
    assign remote_out = ctrl2_ff.level_data
                        && (ctrl2_ff.carrier_suppress || tout_ff[2]);

    // Pins lag the toggle flip-flops by one cycle to stay registered
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            o_ch0_out_pin <= 1'b0;
            o_ch1_out_pin <= 1'b0;
            o_ch2_out_pin <= 1'b0;
            o_irq_flag    <= 3'h0;
        end else begin
            o_ch0_out_pin <= oe_ff[0] && tout_ff[0];
            o_ch1_out_pin <= oe_ff[1] && tout_ff[1];
            o_ch2_out_pin <= ctrl2_ff.out_enable
                             && (carrier_mode ? remote_out : tout_ff[2]);
            o_irq_flag    <= irq_ff;
        end
    end

    // ******************************************************
    // APB slave
    // ******************************************************
    // Write takes effect at the access edge where pready is seen
    assign wr = i_apb.psel && i_apb.penable && i_apb.pwrite && rsp_ff.pready;

    // Answer prepared in setup so every bus output is registered
    always_comb begin
        nxt_rsp = '0;
        nxt_rsp.pready = i_apb.psel && !i_apb.penable;
        unique case (i_apb.paddr)
            `TEC_OFF_MODE0: nxt_rsp.prdata[7:0] = mode_ff[0];
            `TEC_OFF_MODE1: nxt_rsp.prdata[7:0] = mode_ff[1];
            `TEC_OFF_MODE2: nxt_rsp.prdata[7:0] = mode_ff[2];
            `TEC_OFF_CTRL2: nxt_rsp.prdata[7:0] = ctrl2_ff;
            `TEC_OFF_OE0:   nxt_rsp.prdata[0]   = oe_ff[0];
            `TEC_OFF_OE1:   nxt_rsp.prdata[0]   = oe_ff[1];
            `TEC_OFF_MOD0:  nxt_rsp.prdata[7:0] = mod_ff[0];
            `TEC_OFF_MOD1:  nxt_rsp.prdata[7:0] = mod_ff[1];
            `TEC_OFF_MOD2:  nxt_rsp.prdata[7:0] = mod_ff[2];
            `TEC_OFF_CNT0:  nxt_rsp.prdata[7:0] = cnt_ff[0];
            `TEC_OFF_CNT1:  nxt_rsp.prdata[7:0] = cnt_ff[1];
            `TEC_OFF_CNT2:  nxt_rsp.prdata[7:0] = cnt_ff[2];
            `TEC_OFF_IRQ:   nxt_rsp.prdata[2:0] = irq_ff;
            default:        nxt_rsp.pslverr     = nxt_rsp.pready;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff <= nxt_rsp;
        end
    end
    assign o_apb = rsp_ff;

    // Mode registers; a new start write wins over the self-clear
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            for (int n = 0; n < 3; n++) begin
                mode_ff[n] <= `TEC_RST_BYTE;
            end
        end else begin
            for (int n = 0; n < 3; n++) begin
                if (mode_ff[n].start_cmd) begin
                    mode_ff[n].start_cmd <= 1'b0;
                end
            end
            if (wr && i_apb.paddr == `TEC_OFF_MODE0) begin
                mode_ff[0] <= i_apb.pwdata[7:0] & `TEC_MASK_MODE0;
            end
            if (wr && i_apb.paddr == `TEC_OFF_MODE1) begin
                mode_ff[1] <= i_apb.pwdata[7:0] & `TEC_MASK_MODE12;
            end
            if (wr && i_apb.paddr == `TEC_OFF_MODE2) begin
                mode_ff[2] <= i_apb.pwdata[7:0] & `TEC_MASK_MODE12;
            end
        end
    end

    // Channel 1 interrupt latches the next level; beats a software write
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            ctrl2_ff <= `TEC_RST_BYTE;
        end else begin
            if (wr && i_apb.paddr == `TEC_OFF_CTRL2) begin
                ctrl2_ff <= i_apb.pwdata[7:0] & `TEC_MASK_CTRL2;
            end
            if (match[1]) begin
                ctrl2_ff.level_data <= ctrl2_ff.level_data_next;
            end
        end
    end

    // Output enables and modulo values
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            oe_ff <= 2'h0;
            for (int n = 0; n < 3; n++) begin
                mod_ff[n] <= `TEC_RST_MOD;
            end
        end else begin
            if (wr && i_apb.paddr == `TEC_OFF_OE0) begin
                oe_ff[0] <= i_apb.pwdata[0];
            end
            if (wr && i_apb.paddr == `TEC_OFF_OE1) begin
                oe_ff[1] <= i_apb.pwdata[0];
            end
            if (wr && i_apb.paddr == `TEC_OFF_MOD0) begin
                mod_ff[0] <= i_apb.pwdata[7:0];
            end
            if (wr && i_apb.paddr == `TEC_OFF_MOD1) begin
                mod_ff[1] <= i_apb.pwdata[7:0];
            end
            if (wr && i_apb.paddr == `TEC_OFF_MOD2) begin
                mod_ff[2] <= i_apb.pwdata[7:0];
            end
        end
    end

    // ******************************************************
    // Checks
    // ******************************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);

    AST_START_CLEARS: assert property (
        mode_ff[0].start_cmd |=> cnt_ff[0] == 8'h00 && !irq_ff[0])
        else $error("start did not clear counter and flag");
    AST_START_SELF_CLR: assert property (
        mode_ff[1].start_cmd && !(wr && i_apb.paddr == `TEC_OFF_MODE1)
        |=> !mode_ff[1].start_cmd)
        else $error("start bit did not clear itself");
    AST_RUN_HOLD: assert property (
        !mode_ff[0].run && !mode_ff[0].start_cmd |=> $stable(cnt_ff[0]))
        else $error("stopped counter moved");
    AST_TOUT_TOGGLE: assert property (
        match[0] |=> tout_ff[0] != $past(tout_ff[0]))
        else $error("toggle output missed a match");
    AST_TOUT_CLR: assert property (
        mode_ff[1].start_cmd |=> !tout_ff[1])
        else $error("start did not clear toggle output");
    AST_PIN0: assert property (
        oe_ff[0] && tout_ff[0] |=> o_ch0_out_pin)
        else $error("enabled pin did not follow toggle output");
    AST_PIN2_LOW: assert property (
        !ctrl2_ff.out_enable |=> !o_ch2_out_pin)
        else $error("disabled channel 2 pin not low");
    AST_LEVEL_COPY: assert property (
        match[1] |=> ctrl2_ff.level_data == $past(ctrl2_ff.level_data_next))
        else $error("level bit not copied on channel 1 event");
    AST_IRQ_SET: assert property (
        match[2] |=> irq_ff[2] ##1 o_irq_flag[2])
        else $error("interval event did not raise flag");
    AST_GATE_PAUSE: assert property (
        ctrl2_ff.gate_ctrl_enable && !tout_ff[0] && !mode_ff[2].start_cmd
        |=> $stable(cnt_ff[2]))
        else $error("gated counter moved while sampling clock low");
    AST_DIV16: assert property (
        tk[4] |=> !tk[4] [*8] ##8 tk[4])
        else $error("fx/16 tick spacing wrong");

    COV_START: cover property (mode_ff[0].start_cmd ##1 mode_ff[0].run);
    COV_CH1_EVENT: cover property (match[1] && ctrl2_ff.level_data_next);
    COV_CARRIER: cover property (carrier_mode && o_ch2_out_pin);
endmodule : tec_top

/* tec_pin_model.sv */
// Far-side model: event pin driver and channel 2 output pin observer
`timescale 1ns/100ps
module tec_pin_model (
    input  wire logic       i_clk,
    input  wire logic       i_pin2,
    output logic [2:0]      o_event,
    output logic [7:0]      o_rise2
);
    //**************************************************
    // Event pins and pin observer
    //**************************************************
    logic pin2_d;

    // Pins rest low; an external source holds its level between trains
    initial begin
        o_event = 3'b000;
        pin2_d  = 1'b0;
        o_rise2 = 8'h00;
    end

    // Each level held for hold clocks; the synchroniser catches every edge even at 1
    task automatic pulses(input int ch, input int n, input int hold);
        repeat (n) begin
            for (int l = 0; l < 2; l++) begin
                @(posedge i_clk);
                o_event[ch] <= ~o_event[ch];
                repeat (hold - 1) @(posedge i_clk);
            end
        end
    endtask : pulses

    // Count rising edges of the channel 2 pin to judge carrier activity
    always @(posedge i_clk) begin
        pin2_d <= i_pin2;
        if (i_pin2 === 1'b1 && pin2_d === 1'b0) begin
            o_rise2 <= o_rise2 + 8'h01;
        end
    end
endmodule : tec_pin_model

/* test_three_channel_timer_event_counter_ctrl.sv */
// Self-checking bench for the three-channel timer/event counter block
`timescale 1ns/100ps
`include "tec_consts.svh"
module test_three_channel_timer_event_counter_ctrl;
    import tec_pkg::*;
    //**************************************************
    // Signals and tables
    //**************************************************
    localparam logic [11:0] MO [3] = '{`TEC_OFF_MODE0, `TEC_OFF_MODE1, `TEC_OFF_MODE2};
    localparam logic [11:0] MD [3] = '{`TEC_OFF_MOD0, `TEC_OFF_MOD1, `TEC_OFF_MOD2};
    localparam logic [11:0] CN [3] = '{`TEC_OFF_CNT0, `TEC_OFF_CNT1, `TEC_OFF_CNT2};
    localparam logic [11:0] RA [13] = '{`TEC_OFF_MODE0, `TEC_OFF_MODE1, `TEC_OFF_MODE2,
        `TEC_OFF_CTRL2, `TEC_OFF_OE0, `TEC_OFF_OE1, `TEC_OFF_MOD0, `TEC_OFF_MOD1,
        `TEC_OFF_MOD2, `TEC_OFF_CNT0, `TEC_OFF_CNT1, `TEC_OFF_CNT2, `TEC_OFF_IRQ};
    logic           core_clk;
    logic           nrst;
    tec_apb_req_s   apb_req;
    tec_apb_rsp_s   apb_rsp;
    logic [2:0]     event_in;
    logic           pin0;
    logic           pin1;
    logic           pin2;
    logic [2:0]     irq;
    logic [7:0]     rise2;
    logic [31:0]    rd;
    logic [31:0]    a;
    logic           err;
    logic           p;
    int             k;
    int             n_fail;
    int             checked;

    tec_top i_tec_top (
        .i_core_clk    (core_clk),
        .i_nrst        (nrst),
        .i_apb         (apb_req),
        .o_apb         (apb_rsp),
        .i_event_in    (event_in),
        .o_ch0_out_pin (pin0),
        .o_ch1_out_pin (pin1),
        .o_ch2_out_pin (pin2),
        .o_irq_flag    (irq)
    );
    tec_pin_model i_tec_pin_model (
        .i_clk   (core_clk),
        .i_pin2  (pin2),
        .o_event (event_in),
        .o_rise2 (rise2)
    );

    // 100 ns clock
    always #50 core_clk = ~core_clk;

    //**************************************************
    // Tasks
    //**************************************************
    task automatic conclude();
        if (n_fail == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
        checked++;
        if (seen !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, seen);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ad, pwdata: d};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
        if (n >= 50) begin
            chk("pready", 1'b0, 1'b1);
            conclude();
        end
    endtask : apb

    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
    endtask : wr

    task automatic rc(input string nm, input logic [11:0] ad, input logic [31:0] e);
        apb(1'b0, ad, 32'h0);
        chk(nm, rd, e);
    endtask : rc

    task automatic wait_irq(input int b);
        for (k = 0; k < 200 && irq[b] !== 1'b1; k++) @(posedge core_clk);
        if (k >= 200) begin
            chk("irq wait", 1'b0, 1'b1);
            conclude();
        end
    endtask : wait_irq

    // Mode byte: source, start, run, mode
    function automatic logic [31:0] md(input logic [2:0] s, input logic st, input logic r,
                                       input logic [1:0] m);
        return {24'h0, 1'b0, s, st, r, m};
    endfunction : md

    // Start a divided-clock source and check the count after four periods
    task automatic sweep(input int ch, input logic [2:0] code, input int div);
        wr(MD[ch], 32'hff);
        wr(MO[ch], md(code, 1'b1, 1'b1, 2'b00));
        repeat (4 * div) @(posedge core_clk);
        apb(1'b0, CN[ch], 32'h0);
        chk("source rate", (rd >= 3 && rd <= 6), 1'b1);
        wr(MO[ch], 32'h0);
    endtask : sweep

    //**************************************************
    // Main sequence
    //**************************************************
    initial begin
        core_clk = 1'b0;
        nrst = 1'b0;
        apb_req = '0;
        n_fail = 0;
        checked = 0;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        chk("reset pins", {pin0, pin1, pin2, irq}, 32'h0);
        for (int i = 0; i < 13; i++) rc("reset", RA[i], (i > 5 && i < 9) ? 32'hff : 32'h0);
        wr(`TEC_OFF_CTRL2, 32'hff);
        rc("ctrl2 bits", `TEC_OFF_CTRL2, 32'h8f);
        wr(MO[1], 32'h7e);
        rc("mode1 start clear", MO[1], 32'h76);
        wr(MO[0], 32'hff);
        rc("mode0 start clear", MO[0], 32'h74);
        wr(`TEC_OFF_CTRL2, 32'h0);
        wr(MO[1], 32'h0);
        rc("unmapped", 12'hff0, 32'h0);
        chk("unmapped err", err, 1'b1);
        // Channel 0 event counting, hold, match and start clear
        wr(MD[0], 32'h3);
        wr(MO[0], md(3'd0, 1'b1, 1'b1, 2'b00));
        i_tec_pin_model.pulses(0, 2, 2);
        repeat (6) @(posedge core_clk);
        rc("ch0 events", CN[0], 32'h2);
        wr(MO[0], md(3'd0, 1'b0, 1'b0, 2'b00));
        i_tec_pin_model.pulses(0, 2, 3);
        repeat (6) @(posedge core_clk);
        rc("ch0 held", CN[0], 32'h2);
        wr(MO[0], md(3'd0, 1'b0, 1'b1, 2'b00));
        i_tec_pin_model.pulses(0, 2, 2);
        repeat (6) @(posedge core_clk);
        rc("ch0 wrap", CN[0], 32'h0);
        chk("ch0 irq, pin off", {irq[0], pin0}, 2'b10);
        wr(`TEC_OFF_OE0, 32'h1);
        repeat (3) @(posedge core_clk);
        chk("ch0 pin", pin0, 1'b1);
        wr(MO[0], md(3'd0, 1'b1, 1'b1, 2'b00));
        repeat (3) @(posedge core_clk);
        chk("ch0 start", {irq[0], pin0}, 2'b00);
        // Channel 1 falling-edge source
        wr(MD[1], 32'h1);
        wr(MO[1], md(3'd1, 1'b1, 1'b1, 2'b00));
        i_tec_pin_model.pulses(1, 2, 2);
        repeat (6) @(posedge core_clk);
        chk("ch1 fall irq", {irq[1], pin1}, 2'b10);
        wr(`TEC_OFF_OE1, 32'h1);
        repeat (3) @(posedge core_clk);
        chk("ch1 pin", pin1, 1'b1);
        wr(`TEC_OFF_IRQ, 32'h7);
        wr(MO[1], 32'h0);
        // Channel 2 on fx, toggling pin every modulo+1 clocks
        wr(MD[2], 32'h4);
        wr(MO[2], md(3'd3, 1'b1, 1'b1, 2'b00));
        wr(`TEC_OFF_CTRL2, 32'h08);
        wait_irq(2);
        p = pin2;
        for (k = 0; k < 20 && pin2 === p; k++) @(posedge core_clk);
        p = pin2;
        for (k = 0; k < 20 && pin2 === p; k++) @(posedge core_clk);
        chk("ch2 half period", k, 5);
        // Gate: frozen while channel 0 toggle low, counting once it is high
        wr(MD[2], 32'hff);
        wr(`TEC_OFF_CTRL2, 32'h80);
        apb(1'b0, CN[2], 32'h0);
        a = rd;
        repeat (10) @(posedge core_clk);
        rc("gated hold", CN[2], a);
        wr(MD[0], 32'h0);
        i_tec_pin_model.pulses(0, 1, 2);
        repeat (6) @(posedge core_clk);
        apb(1'b0, CN[2], 32'h0);
        a = rd;
        repeat (2) @(posedge core_clk);
        apb(1'b0, CN[2], 32'h0);
        chk("gated run", rd !== a, 1'b1);
        wr(`TEC_OFF_CTRL2, 32'h0);
        repeat (3) @(posedge core_clk);
        chk("ch2 pin off", pin2, 1'b0);
        wr(MO[0], 32'h0);
        wr(MO[2], 32'h0);
        // Every divided-clock source code of each channel
        for (int c = 4; c < 8; c++) begin
            for (int ch = 0; ch < 3; ch++) sweep(ch, c[2:0], (ch == 1 ? 4096 : 1024) >> (2 * (c - 4)));
        end
        sweep(2, 3'd2, 2);
        sweep(2, 3'd3, 1);
        sweep(1, 3'd3, 32);
        // PWM: high while count below modulo
        wr(MD[2], 32'h80);
        wr(MO[2], md(3'd3, 1'b1, 1'b1, 2'b01));
        wr(`TEC_OFF_CTRL2, 32'h08);
        repeat (300) @(posedge core_clk);
        k = 0;
        repeat (256) begin
            @(posedge core_clk);
            k += (pin2 === 1'b1);
        end
        chk("pwm duty", k, 128);
        // Cascade: channel 1 counts channel 2 matches
        wr(MD[2], 32'h3);
        wr(MO[1], md(3'd0, 1'b1, 1'b1, 2'b10));
        wr(MO[2], md(3'd3, 1'b1, 1'b1, 2'b10));
        repeat (40) @(posedge core_clk);
        apb(1'b0, CN[1], 32'h0);
        chk("cascade", (rd >= 8 && rd <= 11), 1'b1);
        // Carrier generator: level, suppress and level copy
        wr(MO[1], md(3'd3, 1'b1, 1'b0, 2'b00));
        wr(MD[2], 32'h1);
        wr(MO[2], md(3'd3, 1'b1, 1'b1, 2'b11));
        wr(`TEC_OFF_CTRL2, 32'h0d);
        repeat (3) @(posedge core_clk);
        chk("steady high", pin2, 1'b1);
        wr(`TEC_OFF_CTRL2, 32'h09);
        a = {24'h0, rise2};
        repeat (20) @(posedge core_clk);
        chk("carrier", (rise2 - a[7:0]) >= 4, 1'b1);
        wr(`TEC_OFF_CTRL2, 32'h0e);
        repeat (3) @(posedge core_clk);
        chk("level low", pin2, 1'b0);
        wr(MD[1], 32'h0);
        wr(MO[1], md(3'd3, 1'b1, 1'b1, 2'b00));
        wait_irq(1);
        repeat (3) @(posedge core_clk);
        chk("level copied", pin2, 1'b1);
        rc("level bit", `TEC_OFF_CTRL2, 32'h0f);
        conclude();
    end
endmodule : test_three_channel_timer_event_counter_ctrl
